// [core/ram_block_pkg.sv]
// Shared constants and types for the embedded RAM block
package ram_block_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int TOTAL_BITS = 4096;
    localparam int MAX_WIDTH = 16;
    localparam int DEF_WIDTH = 16;

    // ---------------------------------------------------------------
    // APB register map (byte addresses)
    // ---------------------------------------------------------------
    localparam int APB_AW = 4;
    localparam logic [APB_AW-1:0] OFS_CTRL = 4'h0;
    localparam logic [APB_AW-1:0] OFS_LOAD_ADDR = 4'h4;
    localparam logic [APB_AW-1:0] OFS_LOAD_DATA = 4'h8;
    localparam logic [APB_AW-1:0] OFS_STATUS = 4'hC;

    // ---------------------------------------------------------------
    // Control register layout, bit 8 down to bit 0
    // ---------------------------------------------------------------
    typedef struct packed {
        logic reg_ren;
        logic reg_raddr;
        logic reg_wen;
        logic reg_waddr;
        logic reg_rdata;
        logic reg_wdata;
        logic split_clk;
        logic rom_mode;
        logic dual_port;
    } ctrl_t;

    localparam int CTRL_W = 9;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

    // Status register fields
    localparam int STAT_DATA_LSB = 0;
    localparam int STAT_ROM_BIT = 16;
    localparam int STAT_DUAL_BIT = 17;

endpackage

// [core/embedded_ram_block.sv]
// Embedded synchronous RAM/ROM block with APB configuration port
`timescale 1ns/100ps

module embedded_ram_block
    import ram_block_pkg::*;
#(
    parameter int WIDTH = DEF_WIDTH,
    parameter int DEPTH = TOTAL_BITS / WIDTH,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and resets
    input wire logic clk,
    input wire logic rstn,
    input wire logic mem_clr,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Cascade select
    input wire logic blk_sel,
    // Write section
    input wire logic wr_tick,
    input wire logic wr_ce,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read section
    input wire logic rd_tick,
    input wire logic rd_ce,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    // No reset on the array: a clear must leave contents intact
    logic [WIDTH-1:0] mem [DEPTH];

    ctrl_t ctrl;
    logic [AW-1:0] load_addr;
    logic arst_n;
    logic wr_fire;
    logic rd_fire;
    logic in_rd_fire;
    logic [AW-1:0] wa_q;
    logic [WIDTH-1:0] wd_q;
    logic we_q;
    logic [AW-1:0] ra_q;
    logic re_q;
    logic [AW-1:0] wa_sel;
    logic [WIDTH-1:0] wd_sel;
    logic we_sel;
    logic [AW-1:0] ra_sel;
    logic re_sel;
    logic [WIDTH-1:0] core_q;
    logic [WIDTH-1:0] out_q;
    logic user_write;
    logic load_write;
    logic apb_wr;
    logic addr_ok;

    // ---------------------------------------------------------------
    // Section strobes and clear
    // ---------------------------------------------------------------
    assign arst_n = rstn & ~mem_clr;
    assign wr_fire = wr_tick & wr_ce;
    // Sections are independent, so a second block can serve a second port
    assign rd_fire = rd_tick & rd_ce;
    // Split scheme moves read-side input registers onto the write tick
    assign in_rd_fire = ctrl.split_clk ? wr_fire : rd_fire;

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    assign pready = 1'b1;
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_LOAD_ADDR) ||
                     (paddr == OFS_LOAD_DATA) || (paddr == OFS_STATUS);
    assign pslverr = psel & penable & ~addr_ok;
    assign apb_wr = psel & penable & pwrite & addr_ok;
    assign load_write = apb_wr && (paddr == OFS_LOAD_DATA);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= ctrl_t'(CTRL_RESET);
        end else if (apb_wr && (paddr == OFS_CTRL)) begin
            ctrl <= ctrl_t'(pwdata[CTRL_W-1:0]);
        end
    end

    // Address auto-increments so a table loads as a word stream
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_addr <= '0;
        end else if (apb_wr && (paddr == OFS_LOAD_ADDR)) begin
            load_addr <= pwdata[AW-1:0];
        end else if (load_write) begin
            load_addr <= load_addr + AW'(1);
        end
    end

    always_comb begin
        prdata = '0;
        unique case (paddr)
            OFS_CTRL: prdata[CTRL_W-1:0] = ctrl;
            OFS_LOAD_ADDR: prdata[AW-1:0] = load_addr;
            OFS_STATUS: begin
                prdata[STAT_DATA_LSB +: WIDTH] = rd_data;
                prdata[STAT_ROM_BIT] = ctrl.rom_mode;
                prdata[STAT_DUAL_BIT] = ctrl.dual_port;
            end
            default: prdata = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // Input registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wa_q <= '0;
            wd_q <= '0;
            we_q <= 1'b0;
        end else if (wr_fire) begin
            wa_q <= wr_addr;
            wd_q <= wr_data;
            we_q <= wr_en;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ra_q <= '0;
            re_q <= 1'b0;
        end else if (in_rd_fire) begin
            ra_q <= rd_addr;
            re_q <= rd_en;
        end
    end

    // Each path independently bypasses its register
    assign wa_sel = ctrl.reg_waddr ? wa_q : wr_addr;
    assign wd_sel = ctrl.reg_wdata ? wd_q : wr_data;
    assign we_sel = ctrl.reg_wen ? we_q : wr_en;
    assign re_sel = ctrl.reg_ren ? re_q : rd_en;
    // Single-port mode reads at the write address
    assign ra_sel = !ctrl.dual_port ? wa_sel : (ctrl.reg_raddr ? ra_q : rd_addr);

    // ---------------------------------------------------------------
    // Write strobe and memory
    // ---------------------------------------------------------------
    // Strobe is generated here from the write tick; ROM mode ignores users
    assign user_write = wr_fire & we_sel & blk_sel & ~ctrl.rom_mode;

    // Configuration load wins over a user write in the same cycle
    always_ff @(posedge clk) begin
        if (load_write) begin
            mem[load_addr] <= pwdata[WIDTH-1:0];
        end else if (user_write) begin
            mem[wa_sel] <= wd_sel;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    // Non-blocking read sees the old word on a same-cycle write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_q <= '0;
        end else if (rd_fire && re_sel) begin
            // Unselected cascade member drives zero so outputs can be ORed
            core_q <= blk_sel ? mem[ra_sel] : '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= '0;
        end else if (rd_fire) begin
            out_q <= core_q;
        end
    end

    assign rd_data = ctrl.reg_rdata ? out_q : core_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] rd_peek;
    logic [WIDTH-1:0] wr_peek;
    assign rd_peek = mem[ra_sel];
    assign wr_peek = mem[wa_sel];

    chk_width_max: assert property (@(posedge clk) WIDTH <= MAX_WIDTH)
        else $error("data width above limit");

    chk_clear_zero: assert property (@(posedge clk)
        mem_clr |-> (core_q == '0) && (out_q == '0) && (wa_q == '0) && !we_q && !re_q)
        else $error("clear left a register set");

    chk_single_addr: assert property (@(posedge clk) disable iff (!rstn)
        !ctrl.dual_port |-> ra_sel == wa_sel)
        else $error("single-port read address differs");

    chk_read_old: assert property (@(posedge clk) disable iff (!arst_n)
        (rd_fire && re_sel && blk_sel && user_write && !load_write && ra_sel == wa_sel)
        |=> core_q == $past(rd_peek))
        else $error("same-cycle read did not return old word");

    chk_write_store: assert property (@(posedge clk) disable iff (!arst_n)
        (user_write && !load_write) |=> mem[$past(wa_sel)] == $past(wd_sel))
        else $error("write strobe did not store data");

    chk_rom_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrl.rom_mode && wr_fire && !load_write) |=> mem[$past(wa_sel)] == $past(wr_peek))
        else $error("ROM content changed by user write");

    chk_read_freeze: assert property (@(posedge clk) disable iff (!arst_n)
        !rd_fire |=> $stable(core_q) && $stable(out_q))
        else $error("read section moved while disabled");

    chk_input_freeze: assert property (@(posedge clk) disable iff (!arst_n)
        !wr_fire |=> $stable(wa_q) && $stable(wd_q) && $stable(we_q))
        else $error("write registers moved while disabled");

    chk_out_pipe: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrl.reg_rdata && rd_fire) ##1 (ctrl.reg_rdata && !mem_clr) |-> rd_data == $past(core_q))
        else $error("registered output did not follow core");

    chk_cascade_gate: assert property (@(posedge clk) disable iff (!arst_n)
        (rd_fire && re_sel && !blk_sel) |=> core_q == '0)
        else $error("unselected block drove read data");

    chk_unmapped_err: assert property (@(posedge clk) disable iff (!rstn)
        (psel && penable && !addr_ok) |-> pslverr && prdata == '0)
        else $error("unmapped access not flagged");

    // ---------------------------------------------------------------
    // Checks on configuration and table loading
    // ---------------------------------------------------------------
    // Array powers up unknown; only written words are ever compared
    // Load port bypasses ROM protection by intent
    chk_load_store: assert property (@(posedge clk) disable iff (!rstn)
        load_write |=> mem[$past(load_addr)] == $past(pwdata[WIDTH-1:0]))
        else $error("table load did not store data");

    chk_load_step: assert property (@(posedge clk) disable iff (!rstn)
        load_write |=> load_addr == $past(load_addr) + AW'(1))
        else $error("load address did not advance");

    chk_ctrl_write: assert property (@(posedge clk) disable iff (!rstn)
        (apb_wr && paddr == OFS_CTRL) |=> ctrl == $past(pwdata[CTRL_W-1:0]))
        else $error("control write not applied");

    chk_ctrl_reset: assert property (@(posedge clk)
        !rstn |-> (ctrl == ctrl_t'(CTRL_RESET)) && (load_addr == '0))
        else $error("reset left configuration set");

    // User clear must not disturb configuration
    chk_ctrl_kept: assert property (@(posedge clk) disable iff (!rstn)
        (mem_clr && !apb_wr) |=> $stable(ctrl))
        else $error("clear changed configuration");

    chk_unmapped_wr: assert property (@(posedge clk) disable iff (!rstn)
        (psel && penable && pwrite && !addr_ok) |=> $stable(ctrl) && $stable(load_addr))
        else $error("unmapped write changed a register");

    // ---------------------------------------------------------------
    // Checks on capture registers and clear
    // ---------------------------------------------------------------
    chk_clear_rest: assert property (@(posedge clk)
        mem_clr |-> (wd_q == '0) && (ra_q == '0) && (rd_data == '0))
        else $error("clear left a path register set");

    chk_wr_capture: assert property (@(posedge clk) disable iff (!arst_n)
        wr_fire |=> (wa_q == $past(wr_addr)) && (wd_q == $past(wr_data))
            && (we_q == $past(wr_en)))
        else $error("write registers missed a capture");

    chk_split_capture: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrl.split_clk && wr_fire) |=> ra_q == $past(rd_addr) && re_q == $past(rd_en))
        else $error("split scheme missed read-side capture");

    chk_split_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrl.split_clk && !wr_fire) |=> $stable(ra_q) && $stable(re_q))
        else $error("split scheme read registers moved");

    chk_rd_capture: assert property (@(posedge clk) disable iff (!arst_n)
        (!ctrl.split_clk && rd_fire) |=> ra_q == $past(rd_addr) && re_q == $past(rd_en))
        else $error("read registers missed a capture");

    chk_rd_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (!ctrl.split_clk && !rd_fire) |=> $stable(ra_q) && $stable(re_q))
        else $error("read registers moved while disabled");

    // ---------------------------------------------------------------
    // Checks on the read path, cascade write blocking and status view
    // ---------------------------------------------------------------
    chk_read_word: assert property (@(posedge clk) disable iff (!arst_n)
        (rd_fire && re_sel && blk_sel) |=> core_q == $past(rd_peek))
        else $error("read returned wrong word");

    chk_single_read: assert property (@(posedge clk) disable iff (!arst_n)
        (!ctrl.dual_port && rd_fire && re_sel && blk_sel) |=> core_q == $past(wr_peek))
        else $error("single-port read missed write address");

    // Deselected member must leave its array alone on user writes; table loads still land
    chk_blk_block: assert property (@(posedge clk) disable iff (!arst_n)
        (!blk_sel && wr_fire && !load_write) |=> mem[$past(wa_sel)] == $past(wr_peek))
        else $error("unselected block accepted a write");

    chk_status_view: assert property (@(posedge clk) disable iff (!rstn)
        (psel && paddr == OFS_STATUS) |-> (prdata[STAT_DATA_LSB +: WIDTH] == rd_data) &&
            (prdata[STAT_ROM_BIT] == ctrl.rom_mode) && (prdata[STAT_DUAL_BIT] == ctrl.dual_port))
        else $error("status view differs from block state");

    // ---------------------------------------------------------------
    // Checks on the APB port
    // ---------------------------------------------------------------
    chk_err_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (psel && penable && addr_ok) |-> !pslverr)
        else $error("mapped access flagged as error");

    chk_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
        !(psel && penable) |-> !pslverr)
        else $error("error flagged outside access phase");

endmodule

// [bench/user_logic_model.sv]
// Model of the user logic driving the RAM block's data ports
`timescale 1ns/100ps
module user_logic_model #(
    parameter int AW = 8,
    parameter int W = 16
) (
    // Clock
    input wire logic clk,
    // Block controls
    output logic mem_clr,
    output logic blk_sel,
    // Write section
    output logic wr_tick,
    output logic wr_ce,
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [W-1:0] wr_data,
    // Read section
    output logic rd_tick,
    output logic rd_ce,
    output logic rd_en,
    output logic [AW-1:0] rd_addr
);
    initial begin
        {mem_clr, wr_tick, wr_ce, wr_en, rd_tick, rd_ce, rd_en} = '0;
        blk_sel = 1'b1;
        {wr_addr, wr_data, rd_addr} = '0;
    end

    // One strobe on both sections; afterwards the address and data lines show inverted values
    task automatic fire(input logic we, re, input logic [1:0] ce,
                        input logic [AW-1:0] wa, ra, input logic [W-1:0] wd);
        @(posedge clk);
        wr_tick <= 1'b1;
        rd_tick <= 1'b1;
        wr_ce <= ce[1];
        rd_ce <= ce[0];
        wr_en <= we;
        rd_en <= re;
        wr_addr <= wa;
        rd_addr <= ra;
        wr_data <= wd;
        @(posedge clk);
        wr_tick <= 1'b0;
        rd_tick <= 1'b0;
        wr_addr <= ~wa;
        rd_addr <= ~ra;
        wr_data <= ~wd;
    endtask

    task automatic set_sel(input logic s);
        @(posedge clk);
        blk_sel <= s;
    endtask

    task automatic pulse_clr();
        @(posedge clk);
        mem_clr <= 1'b1;
        @(posedge clk);
        mem_clr <= 1'b0;
    endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for the embedded RAM block
`timescale 1ns/100ps
module testbench
    import ram_block_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, ev;
    logic mem_clr, blk_sel, wr_tick, wr_ce, wr_en, rd_tick, rd_ce, rd_en;
    logic [7:0] wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data;
    logic [31:0] rv;
    int num_errors = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    embedded_ram_block dut (.clk, .rstn, .mem_clr, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .blk_sel, .wr_tick,
        .wr_ce, .wr_en, .wr_addr, .wr_data, .rd_tick, .rd_ce, .rd_en,
        .rd_addr, .rd_data);

    user_logic_model part (.clk, .mem_clr, .blk_sel, .wr_tick, .wr_ce,
        .wr_en, .wr_addr, .wr_data, .rd_tick, .rd_ce, .rd_en, .rd_addr);

    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_now(input logic [15:0] exp);
        @(negedge clk);
        chk({16'h0, rd_data}, {16'h0, exp});
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_dual();
        chk({16'h0, rd_data}, 32'h0);
        chk({31'h0, pready}, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rv, 32'h0);
        apb(1'b0, 4'h2, 32'h0);
        chk({31'h0, ev}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h001);
        part.fire(1'b1, 1'b0, 2'b11, 8'h05, 8'h00, 16'h1234);
        part.fire(1'b1, 1'b0, 2'b11, 8'hFF, 8'h00, 16'h00FF);
        part.fire(1'b1, 1'b1, 2'b11, 8'h07, 8'h05, 16'h7777);
        rd_now(16'h1234);
        part.fire(1'b1, 1'b1, 2'b11, 8'h05, 8'h05, 16'hABCD);
        rd_now(16'h1234);
        part.fire(1'b0, 1'b1, 2'b11, 8'h00, 8'hFF, 16'h0);
        rd_now(16'h00FF);
        part.fire(1'b0, 1'b1, 2'b11, 8'h00, 8'h05, 16'h0);
        rd_now(16'hABCD);
        part.fire(1'b1, 1'b1, 2'b10, 8'h05, 8'h05, 16'h5555);
        rd_now(16'hABCD);
        part.fire(1'b1, 1'b1, 2'b01, 8'h05, 8'h05, 16'h6666);
        rd_now(16'h5555);
    endtask

    task automatic t_regout_clear();
        apb(1'b1, OFS_CTRL, 32'h011);
        part.fire(1'b0, 1'b1, 2'b11, 8'h00, 8'hFF, 16'h0);
        rd_now(16'h5555);
        part.fire(1'b0, 1'b1, 2'b11, 8'h00, 8'hFF, 16'h0);
        rd_now(16'h00FF);
        part.pulse_clr();
        rd_now(16'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rv, 32'h011);
        part.fire(1'b0, 1'b1, 2'b11, 8'h00, 8'hFF, 16'h0);
        part.fire(1'b0, 1'b1, 2'b11, 8'h00, 8'hFF, 16'h0);
        rd_now(16'h00FF);
    endtask

    task automatic t_rom();
        apb(1'b1, OFS_CTRL, 32'h003);
        apb(1'b1, OFS_LOAD_ADDR, 32'h10);
        apb(1'b1, OFS_LOAD_DATA, 32'hBEEF);
        apb(1'b1, OFS_LOAD_DATA, 32'hCAFE);
        apb(1'b0, OFS_LOAD_ADDR, 32'h0);
        chk(rv, 32'h12);
        part.fire(1'b1, 1'b1, 2'b11, 8'h10, 8'h11, 16'h0);
        rd_now(16'hCAFE);
        part.fire(1'b0, 1'b1, 2'b11, 8'h10, 8'h10, 16'h0);
        rd_now(16'hBEEF);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rv, 32'h0003BEEF);
        part.set_sel(1'b0);
        part.fire(1'b0, 1'b1, 2'b11, 8'h10, 8'h10, 16'h0);
        rd_now(16'h0);
    endtask

    task automatic t_single_regs();
        part.set_sel(1'b1);
        apb(1'b1, OFS_CTRL, 32'h000);
        part.fire(1'b1, 1'b0, 2'b11, 8'h20, 8'h00, 16'h1357);
        part.fire(1'b0, 1'b1, 2'b11, 8'h20, 8'h20, 16'h0);
        rd_now(16'h1357);
        apb(1'b1, OFS_CTRL, 32'h1E9);
        part.fire(1'b1, 1'b0, 2'b11, 8'h21, 8'h00, 16'h2468);
        part.fire(1'b0, 1'b1, 2'b11, 8'h22, 8'h21, 16'h0);
        rd_now(16'h1357);
        part.fire(1'b0, 1'b0, 2'b11, 8'h22, 8'h00, 16'h0);
        rd_now(16'h2468);
        apb(1'b1, OFS_CTRL, 32'h1ED);
        part.fire(1'b0, 1'b1, 2'b10, 8'h00, 8'h20, 16'h0);
        part.fire(1'b0, 1'b0, 2'b01, 8'h00, 8'h21, 16'h0);
        rd_now(16'h1357);
    endtask

    task automatic t_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_now(16'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rv, 32'h0);
        part.fire(1'b0, 1'b1, 2'b11, 8'h21, 8'h00, 16'h0);
        rd_now(16'h2468);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        t_dual();
        t_regout_clear();
        t_rom();
        t_single_regs();
        t_reset();
        end_sim();
    end

    // Whole run needs about 110 cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule
